// *** design/probe_selftest_pkg.sv ***
// Purpose: constants and carrier types for the probe capture path block
// Assumes: APB register access, 32-bit words, byte-wide control latches
// Notes: control byte codes are the values software writes to the latches
package probe_selftest_pkg;
   // Register byte addresses
   localparam logic [7:0] LOGIN_CTRL_ADDR = 8'h00;
   localparam logic [7:0] MEM_CTRL_ADDR = 8'h04;
   localparam logic [7:0] WE_LATCH_ADDR = 8'h08;
   localparam logic [7:0] SEL_STROBE_ADDR = 8'h0C;
   localparam logic [7:0] THRESH_ADDR = 8'h10;
   localparam logic [7:0] STEP_ADDR = 8'h14;
   localparam logic [7:0] STATUS_ADDR = 8'h18;
   localparam logic [7:0] POD_A_ADDR = 8'h2C;
   localparam logic [7:0] POD_B_ADDR = 8'h30;
   localparam logic [7:0] POD_C_ADDR = 8'h34;
   // Control byte codes
   localparam logic [7:0] LOGIN_NORMAL = 8'hEB;
   localparam logic [7:0] LOGIN_DEMUX = 8'hFB;
   localparam logic [7:0] MEM_LOAD = 8'h20;
   localparam logic [7:0] MEM_RUN = 8'h10;
   localparam logic [7:0] MEM_READBACK = 8'h31;
   localparam logic [7:0] WE_ENABLE = 8'h18;
   localparam logic [7:0] WE_DISABLE = 8'h1F;
   localparam logic [7:0] SEL_BYTE = 8'h80;
   localparam logic [7:0] GATE_BYTE = 8'h7F;
   localparam logic [7:0] THRESH_MAX = 8'hFF;
   localparam logic [7:0] THRESH_MIN = 8'h00;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // Step register fields
   localparam int CLK_INIT_BIT = 0;
   localparam int TRIG_STEP_BIT = 1;
   localparam int MOD_STEP_BIT = 2;
   // Selector strobe register fields, master clock count limit, counter load value
   localparam int STROBE_FIRST_BIT = 0;
   localparam int STROBE_FIFTH_BIT = 4;
   localparam logic [5:0] STROBES_REST = 6'h3E;
   localparam logic [5:0] STROBE_FIFTH_ONLY = 6'h10;
   localparam logic [1:0] NUM_MCLK_MAX = 2'h3;
   localparam logic [9:0] ADDR_ZERO = 10'h000;

   typedef struct packed {
      logic login_system_en;
      logic login_probe_en;
      logic demultiplex_enable;
   } login_ctl_t;

   typedef struct packed {
      logic memory_read;
      logic address_counter_enable;
      logic acquisition_readback_enable;
   } mem_ctl_t;
endpackage : probe_selftest_pkg

// *** design/probe_capture_path_selftest.sv ***
// Purpose: probe capture path logic exercised by a host self-test
// Assumes: APB slave, single clock pclk 25 MHz, probe pods on inputs
// Notes: login clock and master clocks are one-cycle enables of pclk
// Notes on behaviour
// - Normal byte: probe login on, demux low
// - Demux byte: probe login on, demux high
// - Load byte: memory read high, counter off
// - Gate byte with first strobe opens gate
// - Select byte, five strobes route step clock
// - Expansion: fifth strobe alone enables step clock
// - Counter loaded zero; write enables go low
// - Run byte: read low, counter held still
// - Max threshold makes every probe read low
// - Clock init clears clock flip-flops
// - Trigger step captures probes into login
// - Module step with write enables low writes one master clock
// - Disable byte drives write enables high
// - Readback byte raises acquisition read signal
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module probe_capture_path_selftest #(
   parameter bit EXPANSION = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [23:0] probe_in,
   output probe_selftest_pkg::login_ctl_t login_ctl,
   output probe_selftest_pkg::mem_ctl_t mem_ctl,
   output logic [2:0] pod_write_enables_n,
   output logic clock_gate_select,
   output logic [9:0] memory_address_counter
);
   ////////////////////////////////////////////////////////////////////
   logic wr_en;
   logic rd_en;
   logic wr_login;
   logic wr_mem;
   logic wr_we;
   logic wr_sel;
   logic wr_thresh;
   logic wr_step;
   logic [7:0] wbyte;
   logic [5:0] strobes;
   logic mapped;
   logic trig_step;
   logic mod_step;
   logic clk_init;
   logic login_clk;
   logic login_ok;
   logic mclk;

   logic [7:0] login_reg;
   logic [7:0] mem_reg;
   logic [7:0] we_reg;
   logic [7:0] thresh_reg;
   logic [7:0] sel_data_reg;
   logic clock_gate_reg;
   logic step_route_reg;
   logic clk_ff_reg;
   logic [23:0] login_data_reg;
   logic [23:0] acq_mem [0:1023];
   logic [23:0] mem_rd_reg;
   logic [1:0] mclk_cnt_reg;
   logic [23:0] probe_level;
   logic [31:0] rdata_next;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign wbyte = pwdata[7:0];
   assign strobes = pwdata[13:8];
   assign wr_login = wr_en && (paddr == probe_selftest_pkg::LOGIN_CTRL_ADDR);
   assign wr_mem = wr_en && (paddr == probe_selftest_pkg::MEM_CTRL_ADDR);
   assign wr_we = wr_en && (paddr == probe_selftest_pkg::WE_LATCH_ADDR);
   assign wr_sel = wr_en && (paddr == probe_selftest_pkg::SEL_STROBE_ADDR);
   assign wr_thresh = wr_en && (paddr == probe_selftest_pkg::THRESH_ADDR);
   assign wr_step = wr_en && (paddr == probe_selftest_pkg::STEP_ADDR);
   assign pready = 1'b1;
   assign mapped = (paddr == probe_selftest_pkg::LOGIN_CTRL_ADDR)
      || (paddr == probe_selftest_pkg::MEM_CTRL_ADDR)
      || (paddr == probe_selftest_pkg::WE_LATCH_ADDR)
      || (paddr == probe_selftest_pkg::SEL_STROBE_ADDR)
      || (paddr == probe_selftest_pkg::THRESH_ADDR)
      || (paddr == probe_selftest_pkg::STEP_ADDR)
      || (paddr == probe_selftest_pkg::STATUS_ADDR)
      || (paddr == probe_selftest_pkg::POD_A_ADDR)
      || (paddr == probe_selftest_pkg::POD_B_ADDR)
      || (paddr == probe_selftest_pkg::POD_C_ADDR);
   assign pslverr = psel && penable && !mapped;

   // Strobes act on a zero written to their bit
   assign clk_init = wr_step
      && !pwdata[probe_selftest_pkg::CLK_INIT_BIT];
   assign trig_step = wr_step && !pwdata[probe_selftest_pkg::TRIG_STEP_BIT];
   assign mod_step = wr_step && !pwdata[probe_selftest_pkg::MOD_STEP_BIT];

   ////////////////////////////////////////////////////////////////////
   // Decoded latch outputs
   assign login_ctl.login_system_en = (login_reg != probe_selftest_pkg::LOGIN_NORMAL)
      && (login_reg != probe_selftest_pkg::LOGIN_DEMUX);
   assign login_ctl.login_probe_en = !login_ctl.login_system_en;
   assign login_ctl.demultiplex_enable =
      (login_reg == probe_selftest_pkg::LOGIN_DEMUX);
   assign mem_ctl.memory_read = (mem_reg == probe_selftest_pkg::MEM_LOAD)
      || (mem_reg == probe_selftest_pkg::MEM_READBACK);
   // Counter never counts in this block; enable only reflects the run byte
   assign mem_ctl.address_counter_enable =
      (mem_reg == probe_selftest_pkg::MEM_RUN);
   assign mem_ctl.acquisition_readback_enable =
      (mem_reg == probe_selftest_pkg::MEM_READBACK);
   assign pod_write_enables_n =
      {3{we_reg != probe_selftest_pkg::WE_ENABLE}};
   assign clock_gate_select = clock_gate_reg;

   // Threshold comparison: max reads all low, min reads probe pins high
   assign probe_level = (thresh_reg == probe_selftest_pkg::THRESH_MAX) ?
      24'h000000 : ((thresh_reg == probe_selftest_pkg::THRESH_MIN) ?
      24'hFFFFFF : probe_in);

   // A set clock flip-flop or closed gate blocks the login clock
   assign login_ok = !clock_gate_reg && step_route_reg && !clk_ff_reg;
   assign login_clk = trig_step && login_ok;
   assign mclk = mod_step && !pod_write_enables_n[0];

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         login_reg <= probe_selftest_pkg::RESET_BYTE;
         mem_reg <= probe_selftest_pkg::RESET_BYTE;
         we_reg <= probe_selftest_pkg::WE_DISABLE;
         thresh_reg <= probe_selftest_pkg::RESET_BYTE;
         sel_data_reg <= probe_selftest_pkg::RESET_BYTE;
      end else begin
         if (wr_login) login_reg <= wbyte;
         if (wr_mem) mem_reg <= wbyte;
         if (wr_we) we_reg <= wbyte;
         if (wr_thresh) thresh_reg <= wbyte;
         if (wr_sel) sel_data_reg <= wbyte;
      end
   end

   // Selector strobes latch the byte on the data field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_gate_reg <= 1'b1;
         step_route_reg <= 1'b0;
      end else if (wr_sel) begin
         if (strobes[probe_selftest_pkg::STROBE_FIRST_BIT]
               && wbyte == probe_selftest_pkg::GATE_BYTE)
            clock_gate_reg <= 1'b0;
         if (!EXPANSION && strobes == probe_selftest_pkg::STROBES_REST)
            step_route_reg <= (wbyte == probe_selftest_pkg::SEL_BYTE);
         if (EXPANSION && strobes == probe_selftest_pkg::STROBE_FIFTH_ONLY)
            step_route_reg <= (wbyte == probe_selftest_pkg::SEL_BYTE);
      end
   end

   // Threshold moves can clock the flip-flop; clock init clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_ff_reg <= 1'b0;
      end else if (clk_init) begin
         clk_ff_reg <= 1'b0;
      end else if (wr_thresh && wbyte != thresh_reg) begin
         clk_ff_reg <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         login_data_reg <= '0;
      end else if (login_clk && login_ctl.login_probe_en) begin
         login_data_reg <= probe_level;
      end
   end

   // Counter load and master clock count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         memory_address_counter <= probe_selftest_pkg::ADDR_ZERO;
         mclk_cnt_reg <= '0;
      end else begin
         if (wr_we && mem_ctl.memory_read && !mem_ctl.address_counter_enable)
            memory_address_counter <= probe_selftest_pkg::ADDR_ZERO;
         if (wr_we)
            mclk_cnt_reg <= '0;
         else if (mclk && mclk_cnt_reg != probe_selftest_pkg::NUM_MCLK_MAX)
            mclk_cnt_reg <= mclk_cnt_reg + 2'h1;
      end
   end

   // Memory array has no reset; it is written by master clocks only
   always_ff @(posedge pclk) begin
      if (mclk)
         acq_mem[memory_address_counter] <= login_data_reg;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         mem_rd_reg <= '0;
      else if (mem_ctl.acquisition_readback_enable)
         mem_rd_reg <= acq_mem[memory_address_counter];
   end

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      rdata_next = '0;
      unique case (paddr)
         probe_selftest_pkg::LOGIN_CTRL_ADDR: rdata_next = {24'h0, login_reg};
         probe_selftest_pkg::MEM_CTRL_ADDR: rdata_next = {24'h0, mem_reg};
         probe_selftest_pkg::WE_LATCH_ADDR: rdata_next = {24'h0, we_reg};
         probe_selftest_pkg::SEL_STROBE_ADDR: rdata_next = {24'h0, sel_data_reg};
         probe_selftest_pkg::THRESH_ADDR: rdata_next = {24'h0, thresh_reg};
         probe_selftest_pkg::STATUS_ADDR: rdata_next = {20'h0, mclk_cnt_reg,
            clk_ff_reg, step_route_reg, clock_gate_reg, login_ok,
            memory_address_counter[5:0]};
         probe_selftest_pkg::POD_A_ADDR: rdata_next = {24'h0, mem_rd_reg[7:0]};
         probe_selftest_pkg::POD_B_ADDR: rdata_next = {24'h0, mem_rd_reg[15:8]};
         probe_selftest_pkg::POD_C_ADDR: rdata_next = {24'h0, mem_rd_reg[23:16]};
         default: rdata_next = '0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= '0;
      else if (rd_en)
         prdata <= rdata_next;
   end

   ////////////////////////////////////////////////////////////////////
   sequence s_login_write(logic [7:0] code);
      wr_login && wbyte == code;
   endsequence

   property p_normal;
      @(posedge pclk) disable iff (!presetn)
      s_login_write(probe_selftest_pkg::LOGIN_NORMAL) |=>
         login_ctl.login_probe_en && !login_ctl.demultiplex_enable;
   endproperty
   a_normal: assert property (p_normal) else $error("normal login wrong");

   property p_demux;
      @(posedge pclk) disable iff (!presetn)
      s_login_write(probe_selftest_pkg::LOGIN_DEMUX) |=>
         login_ctl.login_probe_en && login_ctl.demultiplex_enable;
   endproperty
   a_demux: assert property (p_demux) else $error("demux login wrong");

   property p_load;
      @(posedge pclk) disable iff (!presetn)
      (wr_mem && wbyte == probe_selftest_pkg::MEM_LOAD) |=>
         mem_ctl.memory_read && !mem_ctl.address_counter_enable;
   endproperty
   a_load: assert property (p_load) else $error("load setup wrong");

   property p_gate;
      @(posedge pclk) disable iff (!presetn)
      (wr_sel && strobes[0] && wbyte == probe_selftest_pkg::GATE_BYTE)
         |=> !clock_gate_select;
   endproperty
   a_gate: assert property (p_gate) else $error("gate not open");

   property p_we_low;
      @(posedge pclk) disable iff (!presetn)
      (wr_we && wbyte == probe_selftest_pkg::WE_ENABLE) |=>
         pod_write_enables_n == 3'h0;
   endproperty
   a_we_low: assert property (p_we_low) else $error("enables not low");

   property p_run;
      @(posedge pclk) disable iff (!presetn)
      mem_ctl.address_counter_enable |=> $stable(memory_address_counter);
   endproperty
   a_run: assert property (p_run) else $error("counter moved");

   property p_init;
      @(posedge pclk) disable iff (!presetn)
      clk_init ##1 !wr_thresh |=> !clk_ff_reg;
   endproperty
   a_init: assert property (p_init) else $error("clock ff not cleared");

   property p_we_high;
      @(posedge pclk) disable iff (!presetn)
      (wr_we && wbyte == probe_selftest_pkg::WE_DISABLE) |=>
         pod_write_enables_n == 3'h7 ##1 !mclk;
   endproperty
   a_we_high: assert property (p_we_high) else $error("enables not high");

   property p_readback;
      @(posedge pclk) disable iff (!presetn)
      (wr_mem && wbyte == probe_selftest_pkg::MEM_READBACK) |=>
         mem_ctl.acquisition_readback_enable && mem_ctl.memory_read;
   endproperty
   a_readback: assert property (p_readback) else $error("readback off");

   // The strobe pattern that routes the step clock depends on the board
   sequence s_route_write;
      wr_sel && wbyte == probe_selftest_pkg::SEL_BYTE
         && strobes == (EXPANSION ? probe_selftest_pkg::STROBE_FIFTH_ONLY
         : probe_selftest_pkg::STROBES_REST);
   endsequence

   property p_route;
      @(posedge pclk) disable iff (!presetn)
      s_route_write |=> step_route_reg;
   endproperty
   a_route: assert property (p_route) else $error("route off");

   property p_capture_low;
      @(posedge pclk) disable iff (!presetn)
      (login_clk && login_ctl.login_probe_en
         && thresh_reg == probe_selftest_pkg::THRESH_MAX)
         |=> login_data_reg == '0;
   endproperty
   a_capture_low: assert property (p_capture_low) else $error("not low");

   property p_capture;
      @(posedge pclk) disable iff (!presetn)
      (login_clk && login_ctl.login_probe_en)
         |=> login_data_reg == $past(probe_level);
   endproperty
   a_capture: assert property (p_capture) else $error("no capture");

   // Count saturates so a runaway step stream cannot wrap back to zero
   property p_mclk_count;
      @(posedge pclk) disable iff (!presetn)
      (mclk && mclk_cnt_reg != probe_selftest_pkg::NUM_MCLK_MAX)
         |=> mclk_cnt_reg == $past(mclk_cnt_reg) + 2'h1;
   endproperty
   a_mclk_count: assert property (p_mclk_count) else $error("no mclk");

   property p_counter_load;
      @(posedge pclk) disable iff (!presetn)
      (wr_we && wbyte == probe_selftest_pkg::WE_ENABLE
         && mem_ctl.memory_read && !mem_ctl.address_counter_enable)
         |=> memory_address_counter == probe_selftest_pkg::ADDR_ZERO;
   endproperty
   a_counter_load: assert property (p_counter_load) else $error("no load");
endmodule : probe_capture_path_selftest

// *** dv/probe_pod_model.sv ***
// Purpose: pod receiver model feeding the probe inputs
// Assumes: one clock, levels presented right after a rising edge
// Notes: unheld pods toggle so a stale capture cannot pass by luck
`timescale 1ns/1ps
module probe_pod_model (
   input wire logic pclk,
   input wire logic hold,
   input wire logic [23:0] pattern,
   output logic [23:0] probe_in
);
   initial probe_in = 24'h000000;
   always @(posedge pclk) begin
      probe_in <= hold ? pattern : ~probe_in;
   end
endmodule : probe_pod_model

// *** dv/probe_capture_path_selftest_tb_top.sv ***
// Purpose: self-checking bench acting as host for the capture self-test
// Assumes: APB master tasks, pready answers within 16 cycles
// Notes: passes cover both login modes at both threshold limits
`timescale 1ns/1ps
module probe_capture_path_selftest_tb_top;
   logic pclk, presetn, psel, penable, pwrite, hold, pslverr, pready;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [23:0] probe_in, pattern;
   logic [2:0] pod_write_enables_n;
   logic clock_gate_select;
   logic [9:0] memory_address_counter;
   logic [31:0] x_prdata;
   logic [7:0] last_thr;
   probe_selftest_pkg::login_ctl_t login_ctl;
   probe_selftest_pkg::mem_ctl_t mem_ctl;
   int fail_count = 0;
   int num_checks = 0;
   //////////////////////////////////////////////////////////////////////
   probe_capture_path_selftest #(.EXPANSION(1'b0))
         probe_capture_path_selftest_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .probe_in(probe_in), .login_ctl(login_ctl), .mem_ctl(mem_ctl),
      .pod_write_enables_n(pod_write_enables_n),
      .clock_gate_select(clock_gate_select),
      .memory_address_counter(memory_address_counter));
   probe_pod_model probe_pod_model_inst (.pclk(pclk), .hold(hold),
      .pattern(pattern), .probe_in(probe_in));
   // Expansion board sits on the same bus; only its read data is watched
   probe_capture_path_selftest #(.EXPANSION(1'b1))
         probe_capture_path_selftest_exp_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(x_prdata), .pready(),
      .pslverr(), .probe_in(probe_in), .login_ctl(), .mem_ctl(),
      .pod_write_enables_n(), .clock_gate_select(),
      .memory_address_counter());
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   //////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask : chk
   task automatic chk_pod(input logic [7:0] a, input logic [7:0] got,
         input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t port=%h got=%h exp=%h", $time, a, got, exp);
         fail_count++;
      end
   endtask : chk_pod
   // Request held until pready is seen high at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         fail_count++;
         stop_test();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      xfer(1'b1, a, d, q, e);
      chk(32'(e), 32'h0);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      xfer(1'b0, a, 32'h0, q, e);
   endtask : rd
   function automatic logic [7:0] exp_pod(input logic [7:0] thr,
         input logic [23:0] pin, input int i);
      if (thr == probe_selftest_pkg::THRESH_MAX) return 8'h00;
      if (thr == probe_selftest_pkg::THRESH_MIN) return 8'hFF;
      return pin[i*8 +: 8];
   endfunction : exp_pod
   //////////////////////////////////////////////////////////////////////
   task automatic run_pass(input logic [7:0] mode, input logic [7:0] thr);
      logic [31:0] q;
      logic [7:0] pods [3];
      pods = '{probe_selftest_pkg::POD_A_ADDR,
         probe_selftest_pkg::POD_B_ADDR, probe_selftest_pkg::POD_C_ADDR};
      @(posedge pclk);
      pattern <= 24'($urandom);
      wr(probe_selftest_pkg::LOGIN_CTRL_ADDR, {24'h0, mode});
      chk(32'(login_ctl), {29'h0, 2'b01, mode == 8'hFB});
      wr(probe_selftest_pkg::MEM_CTRL_ADDR, 32'h20);
      chk(32'(mem_ctl[2:1]), 32'h2);
      wr(probe_selftest_pkg::SEL_STROBE_ADDR, 32'h017F);
      chk(32'(clock_gate_select), 32'h0);
      wr(probe_selftest_pkg::SEL_STROBE_ADDR, 32'h3E80);
      wr(probe_selftest_pkg::SEL_STROBE_ADDR, 32'h1080);
      rd(probe_selftest_pkg::STATUS_ADDR, q);
      chk(32'(q[8]), 32'h1);
      chk(32'(x_prdata[8]), 32'h1);
      wr(probe_selftest_pkg::WE_LATCH_ADDR, 32'h18);
      chk(32'({pod_write_enables_n, memory_address_counter}), 32'h0);
      wr(probe_selftest_pkg::MEM_CTRL_ADDR, 32'h10);
      chk(32'(mem_ctl[2:1]), 32'h1);
      wr(probe_selftest_pkg::THRESH_ADDR, {24'h0, thr});
      rd(probe_selftest_pkg::STATUS_ADDR, q);
      chk(32'(q[9]), 32'(thr != last_thr));
      last_thr = thr;
      wr(probe_selftest_pkg::STEP_ADDR, 32'h6);
      rd(probe_selftest_pkg::STATUS_ADDR, q);
      chk(32'(q[9]), 32'h0);
      wr(probe_selftest_pkg::STEP_ADDR, 32'h5);
      repeat (3) wr(probe_selftest_pkg::STEP_ADDR, 32'h3);
      rd(probe_selftest_pkg::STATUS_ADDR, q);
      chk(32'(q[11:10]), 32'h3);
      wr(probe_selftest_pkg::WE_LATCH_ADDR, 32'h1F);
      chk(32'(pod_write_enables_n), 32'h7);
      wr(probe_selftest_pkg::MEM_CTRL_ADDR, 32'h31);
      chk(32'(mem_ctl.acquisition_readback_enable), 32'h1);
      repeat (2) @(posedge pclk);
      for (int i = 0; i < 3; i++) begin
         rd(pods[i], q);
         chk_pod(pods[i], q[7:0], exp_pod(thr, pattern, i));
      end
      if (thr == 8'hFF && fail_count != 0) stop_test();
   endtask : run_pass
   //////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] q;
      logic e;
      logic [7:0] mid;
      void'($urandom(32'h610FA704));
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      hold = 1'b0;
      pattern = 24'h0;
      last_thr = probe_selftest_pkg::THRESH_MIN;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      hold <= 1'b1;
      @(negedge pclk);
      chk(32'({pod_write_enables_n, clock_gate_select}), 32'hF);
      chk(32'(memory_address_counter), 32'h0);
      xfer(1'b1, 8'hFC, 32'hFFFFFFFF, q, e);
      chk(32'(e), 32'h1);
      xfer(1'b0, 8'hFC, 32'h0, q, e);
      chk({q[30:0], e}, 32'h1);
      run_pass(8'hEB, 8'hFF);
      run_pass(8'hEB, 8'h00);
      run_pass(8'hFB, 8'hFF);
      run_pass(8'hFB, 8'h00);
      for (int k = 0; k < 3; k++) begin
         mid = 8'($urandom_range(8'hFE, 8'h01));
         run_pass(8'hEB, mid);
      end
      stop_test();
   end
endmodule : probe_capture_path_selftest_tb_top
